// *** rtl/i2cs_pkg.sv ***
// Package for the two-wire bus slave unit: register map, field positions,
// reset values, state codes and carrier structs.
// Assumes a 32-bit Avalon-MM register port and synchronous bus pin samples.
package i2cs_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] REG_RECEIVE_HOLDING = 8'h00;
  localparam logic [7:0] REG_TRANSMIT_HOLDING = 8'h04;
  localparam logic [7:0] REG_BAUD_RELOAD = 8'h08;
  localparam logic [7:0] REG_BUS_CONTROL = 8'h0c;
  localparam logic [7:0] REG_BUS_STATUS = 8'h10;
  localparam logic [7:0] REG_OWN_ADDRESS = 8'h14;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CON_MODULE_ENABLE = 15;
  localparam int CON_CLOCK_RELEASE = 12;
  localparam int CON_TEN_BIT_SELECT = 10;
  localparam int CON_RECEIVE_STRETCH = 6;
  localparam logic [15:0] CON_RESET = 16'h1000;
  localparam int ST_RECEIVE_FULL = 0;
  localparam int ST_TRANSMIT_FULL = 1;
  localparam int ST_READ_WRITE = 2;
  localparam int ST_DATA_ADDRESS = 5;
  localparam int ST_RO_BITS = 6;
  localparam int ST_OVERFLOW = 0;
  localparam int ST_TEN_BIT_MATCH = 2;
  localparam logic [9:0] ST_UPPER_RESET = 10'h000;
  localparam logic [8:0] BAUD_RESET = 9'h000;
  localparam logic [9:0] OWN_ADDRESS_RESET = 10'h000;
  localparam logic [7:0] HOLDING_RESET = 8'h00;

  // ************************************************************
  // Address codes and byte framing
  // ************************************************************
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [6:0] CODE_VALID_LO = 7'h04;
  localparam logic [6:0] CODE_VALID_HI = 7'h77;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [6:0] {
    I2CS_IDLE = 7'h01,
    I2CS_ADDR = 7'h02,
    I2CS_ADDR_LOW = 7'h04,
    I2CS_RX = 7'h08,
    I2CS_TX = 7'h10,
    I2CS_ACK_OUT = 7'h20,
    I2CS_ACK_IN = 7'h40
  } i2cs_state_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } i2cs_avs_req_s;

  typedef struct packed {
    logic scl_o;
    logic scl_oe_n;
    logic sda_o;
    logic sda_oe_n;
  } i2cs_line_s;

endpackage

// *** rtl/i2cs_slave.sv ***
// Two-wire bus slave: address match, receive double buffer, single transmit
// holding register, clock stretching, Avalon-MM register slave.
// Assumes bus pin samples are synchronous to i_sys_clk (25 MHz).
//
// Overview of operation
// - Control read/write; status low six read-only
// - Full byte moves to holding, pulses event
// - Transmit uses the single holding register only
// - Own address register holds ten bits
// - Control bit ten selects addressing mode
// - Seven-bit: address bits match shift bits
// - Ten-bit: prefix byte first, then low byte
// - Enabled slave idles until Start, shifts address
// - Incoming bits sampled on clock rising edge
// - Match acknowledged, event at ninth falling edge
// - Address byte leaves holding and full flag
// - Read direction: ack, hold clock until loaded
// - Release bit frees clock, eight bits out
// - Transmit data changes on falling clock edges
// - Event after each sent byte, any ack
// - Write direction: load holding, ack when empty
// - Full holding: no ack, discard, still event
// - Overflow set, holding empty: load, no ack
// - Repeated Start in ten-bit: prefix suffices
// - Nine-bit baud reload register provided
// - Reserved and ten-bit codes never match seven-bit
// - Transmit stretches only with holding empty, regardless of enable
// - Write prefix clears, low match sets flag
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module i2cs_slave
#(
  parameter int BAUD_W = 9
)
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire i2cs_pkg::i2cs_avs_req_s i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_scl,
  input wire logic i_sda,
  output i2cs_pkg::i2cs_line_s o_line,
  output logic o_slave_event,
  output logic [BAUD_W-1:0] o_baud_reload
);
  import i2cs_pkg::*;

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (BAUD_W != 9)
  begin : g_bad_width
    $error("i2cs_slave: baud reload width must be 9");
  end

  // ************************************************************
  // Storage
  // ************************************************************
  logic bus_ack;
  logic [15:0] bus_control;
  logic [9:0] status_upper;
  logic receive_full_flag;
  logic transmit_full;
  logic last_read_write;
  logic last_was_data;
  logic [7:0] receive_holding;
  logic [7:0] transmit_holding;
  logic [8:0] baud_reload_value;
  logic [9:0] own_slave_address;
  i2cs_state_e state;
  i2cs_state_e after_ack;
  logic [3:0] bit_count;
  logic [7:0] receive_shift_register;
  logic [7:0] tx_shift;
  logic tx_loaded;
  logic master_nack;
  logic sda_pull;
  logic scl_hold;
  logic scl_q;
  logic sda_q;
  logic slave_event_flag;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic hit(input i2cs_avs_req_s req, input logic [7:0] off);
    hit = req.address == off;
  endfunction

  function automatic logic seven_bit_hit(input logic [7:0] rsr, input logic [9:0] own);
    logic ok;
    ok = (rsr[7:1] >= CODE_VALID_LO) && (rsr[7:1] <= CODE_VALID_HI);
    seven_bit_hit = ok && (rsr[7:1] == own[6:0]);
  endfunction

  function automatic logic prefix_hit(input logic [7:0] rsr, input logic [9:0] own);
    prefix_hit = (rsr[7:3] == TEN_BIT_PREFIX) && (rsr[2:1] == own[9:8]);
  endfunction

  // ************************************************************
  // Bus edges and events
  // ************************************************************
  logic module_enable_bit;
  logic ten_bit_address_select;
  logic receive_stretch_enable;
  logic clock_release_bit;
  logic receive_overflow_flag;
  logic ten_bit_match_flag;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic ninth_fall;
  logic rx_load;
  logic rx_refuse;
  logic tx_load;
  logic stretch_now;
  logic bus_wr;
  logic holding_read;

  assign module_enable_bit = bus_control[CON_MODULE_ENABLE];
  assign ten_bit_address_select = bus_control[CON_TEN_BIT_SELECT];
  assign receive_stretch_enable = bus_control[CON_RECEIVE_STRETCH];
  assign clock_release_bit = bus_control[CON_CLOCK_RELEASE];
  assign receive_overflow_flag = status_upper[ST_OVERFLOW];
  assign ten_bit_match_flag = status_upper[ST_TEN_BIT_MATCH];
  assign scl_rise = ~scl_q & i_scl;
  assign scl_fall = scl_q & ~i_scl;
  assign start_seen = scl_q & i_scl & sda_q & ~i_sda;
  assign stop_seen = scl_q & i_scl & ~sda_q & i_sda;
  assign byte_done = scl_fall && (bit_count == BYTE_BITS)
    && (state inside {I2CS_ADDR, I2CS_ADDR_LOW, I2CS_RX});
  assign ninth_fall = scl_fall && (state inside {I2CS_ACK_OUT, I2CS_ACK_IN});
  assign rx_load = byte_done && (state == I2CS_RX) && !receive_full_flag;
  assign rx_refuse = byte_done && (state == I2CS_RX) && receive_full_flag;
  assign tx_load = (state == I2CS_TX) && !tx_loaded && transmit_full;
  assign stretch_now = ninth_fall && (((state == I2CS_ACK_OUT) && (after_ack == I2CS_TX)
    && !transmit_full)
    || ((after_ack == I2CS_RX) && receive_stretch_enable && receive_full_flag)
    || ((state == I2CS_ACK_IN) && !master_nack && !transmit_full));
  assign bus_wr = i_avs.write & bus_ack;
  assign holding_read = i_avs.read & bus_ack & hit(i_avs, REG_RECEIVE_HOLDING);

  // ************************************************************
  // Avalon-MM slave: one wait state, then answer
  // ************************************************************
  assign o_avs_waitrequest = (i_avs.read | i_avs.write) & ~bus_ack;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      bus_ack <= 1'b0;
    else
      bus_ack <= (i_avs.read | i_avs.write) & ~bus_ack;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_avs_readdata <= 32'h0000_0000;
    else if (i_avs.read & ~bus_ack)
    begin
      case (i_avs.address)
        REG_RECEIVE_HOLDING: o_avs_readdata <= {24'h00_0000, receive_holding};
        REG_TRANSMIT_HOLDING: o_avs_readdata <= {24'h00_0000, transmit_holding};
        REG_BAUD_RELOAD: o_avs_readdata <= {23'h00_0000, baud_reload_value};
        REG_BUS_CONTROL: o_avs_readdata <= {16'h0000, bus_control};
        REG_BUS_STATUS: o_avs_readdata <= {16'h0000, status_upper, last_was_data,
          2'b00, last_read_write, transmit_full, receive_full_flag};
        REG_OWN_ADDRESS: o_avs_readdata <= {22'h00_0000, own_slave_address};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      bus_control <= CON_RESET;
    end
    else
    begin
      if (stretch_now)
        bus_control[CON_CLOCK_RELEASE] <= 1'b0;
      if (bus_wr && hit(i_avs, REG_BUS_CONTROL))
      begin
        bus_control <= i_avs.writedata[15:0];
        if (!receive_stretch_enable && !i_avs.writedata[CON_CLOCK_RELEASE])
          bus_control[CON_CLOCK_RELEASE] <= clock_release_bit & ~stretch_now;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      baud_reload_value <= BAUD_RESET;
      own_slave_address <= OWN_ADDRESS_RESET;
      transmit_holding <= HOLDING_RESET;
    end
    else if (bus_wr)
    begin
      if (hit(i_avs, REG_BAUD_RELOAD))
        baud_reload_value <= i_avs.writedata[8:0];
      if (hit(i_avs, REG_OWN_ADDRESS))
        own_slave_address <= i_avs.writedata[9:0];
      if (hit(i_avs, REG_TRANSMIT_HOLDING))
        transmit_holding <= i_avs.writedata[7:0];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      transmit_full <= 1'b0;
    else if (bus_wr && hit(i_avs, REG_TRANSMIT_HOLDING))
      transmit_full <= 1'b1;
    else if (tx_load)
      transmit_full <= 1'b0;
  end

  // ************************************************************
  // Receive holding and status flags
  // ************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      receive_holding <= HOLDING_RESET;
      receive_full_flag <= 1'b0;
    end
    else if (rx_load)
    begin
      receive_holding <= receive_shift_register;
      receive_full_flag <= 1'b1;
    end
    else if (holding_read)
      receive_full_flag <= 1'b0;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      status_upper <= ST_UPPER_RESET;
    else
    begin
      if (bus_wr && hit(i_avs, REG_BUS_STATUS))
        status_upper <= i_avs.writedata[15:ST_RO_BITS];
      if (rx_refuse)
        status_upper[ST_OVERFLOW] <= 1'b1;
      if (byte_done && (state == I2CS_ADDR) && ten_bit_address_select)
        status_upper[ST_TEN_BIT_MATCH] <= prefix_hit(receive_shift_register,
          own_slave_address) && receive_shift_register[0] && ten_bit_match_flag;
      if (byte_done && (state == I2CS_ADDR_LOW))
        status_upper[ST_TEN_BIT_MATCH] <= receive_shift_register
          == own_slave_address[7:0];
      if (start_seen && !ten_bit_address_select)
        status_upper[ST_TEN_BIT_MATCH] <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      last_read_write <= 1'b0;
      last_was_data <= 1'b0;
    end
    else if (byte_done)
    begin
      last_was_data <= state == I2CS_RX;
      if (state == I2CS_ADDR)
        last_read_write <= receive_shift_register[0];
    end
    else if (ninth_fall && (state == I2CS_ACK_IN))
      last_was_data <= 1'b1;
  end

  // ************************************************************
  // Byte decision: acknowledge and next phase
  // ************************************************************
  logic next_ack;
  i2cs_state_e next_after;

  always_comb
  begin
    next_ack = 1'b0;
    next_after = I2CS_IDLE;
    case (state)
      I2CS_ADDR:
      begin
        if (!ten_bit_address_select)
        begin
          next_ack = seven_bit_hit(receive_shift_register, own_slave_address);
          next_after = receive_shift_register[0] ? I2CS_TX : I2CS_RX;
        end
        else if (prefix_hit(receive_shift_register, own_slave_address))
        begin
          next_ack = !receive_shift_register[0] || ten_bit_match_flag;
          next_after = receive_shift_register[0] ? I2CS_TX : I2CS_ADDR_LOW;
        end
      end
      I2CS_ADDR_LOW:
      begin
        next_ack = receive_shift_register == own_slave_address[7:0];
        next_after = I2CS_RX;
      end
      I2CS_RX:
      begin
        next_ack = !receive_full_flag && !receive_overflow_flag;
        next_after = I2CS_RX;
      end
      default:
      begin
        next_ack = 1'b0;
        next_after = I2CS_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Serial engine
  // ************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || !module_enable_bit)
    begin
      state <= I2CS_IDLE;
      after_ack <= I2CS_IDLE;
      bit_count <= 4'h0;
      receive_shift_register <= 8'h00;
      tx_shift <= 8'h00;
      tx_loaded <= 1'b0;
      master_nack <= 1'b0;
      sda_pull <= 1'b0;
    end
    else if (start_seen)
    begin
      state <= I2CS_ADDR;
      bit_count <= 4'h0;
      tx_loaded <= 1'b0;
      sda_pull <= 1'b0;
    end
    else if (stop_seen)
    begin
      state <= I2CS_IDLE;
      sda_pull <= 1'b0;
    end
    else
    begin
      case (state)
        I2CS_ADDR, I2CS_ADDR_LOW, I2CS_RX:
        begin
          if (scl_rise)
          begin
            receive_shift_register <= {receive_shift_register[6:0], i_sda};
            bit_count <= bit_count + 4'h1;
          end
          else if (byte_done)
          begin
            state <= (next_ack || state == I2CS_RX) ? I2CS_ACK_OUT : I2CS_IDLE;
            sda_pull <= next_ack;
            after_ack <= next_after;
          end
        end
        I2CS_ACK_OUT:
        begin
          if (ninth_fall)
          begin
            sda_pull <= 1'b0;
            bit_count <= 4'h0;
            tx_loaded <= 1'b0;
            state <= after_ack;
          end
        end
        I2CS_TX:
        begin
          if (tx_load)
          begin
            tx_shift <= transmit_holding;
            tx_loaded <= 1'b1;
            sda_pull <= ~transmit_holding[7];
          end
          else if (scl_rise)
            bit_count <= bit_count + 4'h1;
          else if (scl_fall && tx_loaded && (bit_count != 4'h0))
          begin
            if (bit_count == BYTE_BITS)
            begin
              sda_pull <= 1'b0;
              state <= I2CS_ACK_IN;
            end
            else
            begin
              tx_shift <= {tx_shift[6:0], 1'b0};
              sda_pull <= ~tx_shift[6];
            end
          end
        end
        I2CS_ACK_IN:
        begin
          if (scl_rise)
            master_nack <= i_sda;
          else if (ninth_fall)
          begin
            bit_count <= 4'h0;
            tx_loaded <= 1'b0;
            state <= master_nack ? I2CS_IDLE : I2CS_TX;
          end
        end
        default:
          state <= I2CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      slave_event_flag <= 1'b0;
    else
      slave_event_flag <= ninth_fall && module_enable_bit && !start_seen && !stop_seen;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      scl_hold <= 1'b0;
    else
      scl_hold <= module_enable_bit && !clock_release_bit && (scl_hold || !i_scl);
  end

  assign o_line.scl_o = 1'b0;
  assign o_line.scl_oe_n = ~scl_hold;
  assign o_line.sda_o = 1'b0;
  assign o_line.sda_oe_n = ~sda_pull;
  assign o_slave_event = slave_event_flag;
  assign o_baud_reload = baud_reload_value;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence s_ack_cycle;
    ninth_fall ##1 slave_event_flag;
  endsequence

  a_holding_load: assert property (rx_load |=> receive_full_flag
    && receive_holding == $past(receive_shift_register))
    else $error("holding register not loaded on byte end");
  a_full_refuse: assert property (rx_refuse |=> !sda_pull
    && receive_overflow_flag && $stable(receive_holding))
    else $error("full holding not refused");
  a_addr_keeps_rcv: assert property (byte_done && state != I2CS_RX
    |=> $stable(receive_holding) ##1 $stable(receive_holding))
    else $error("address byte disturbed holding");
  a_seven_match: assert property (byte_done && state == I2CS_ADDR && !start_seen
    && !ten_bit_address_select
    && seven_bit_hit(receive_shift_register, own_slave_address)
    |=> sda_pull && state == I2CS_ACK_OUT)
    else $error("seven-bit match not acknowledged");
  a_event_ninth: assert property (ninth_fall && !start_seen && !stop_seen
    |-> s_ack_cycle)
    else $error("event missing after ninth clock");
  a_tx_stretch: assert property (stretch_now && after_ack == I2CS_TX
    && !(bus_wr && hit(i_avs, REG_BUS_CONTROL)) |=> !clock_release_bit ##1 scl_hold)
    else $error("transmit stretch missing");
  a_tx_on_fall: assert property (state == I2CS_TX && tx_loaded && $past(tx_loaded)
    && $changed(sda_pull)
    |-> $past(scl_fall))
    else $error("transmit data changed off falling edge");
  a_bus_wait: assert property ((i_avs.read || i_avs.write) && !bus_ack
    |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus answer not after one wait state");
  a_ro_status: assert property (bus_wr && hit(i_avs, REG_BUS_STATUS) && !rx_load
    && !holding_read |=> $stable(receive_full_flag))
    else $error("read-only status bit written");

endmodule

// *** verification/i2cs_master_model.sv ***
// Behavioural two-wire bus master for the slave bench.
// Assumes pull-ups on both lines; paced by the system clock.
`timescale 1ns/1ps

module i2cs_master_model
#(
  parameter int HALF = 6
)
(
  input wire logic i_sys_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  int stall_err = 0;
  int hold_err = 0;
  logic reading = 1'b0;
  logic p_scl;
  logic p_sda;

  initial o_scl = 1'b1;
  initial o_sda = 1'b1;

  // ************************************************************
  // Bit and byte sequences
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // Release clock, wait while the slave stretches it
  task automatic rise();
    int n;
    n = 0;
    o_scl <= 1'b1;
    tick(1);
    while (i_scl !== 1'b1 && n < 3000)
    begin
      tick(1);
      n++;
    end
    if (n == 3000)
      stall_err++;
    tick(HALF);
  endtask

  task automatic bit_io(input logic b, output logic s);
    o_sda <= b;
    tick(HALF);
    rise();
    s = i_sda;
    o_scl <= 1'b0;
    tick(HALF);
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    reading = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    reading = 1'b0;
    bit_io(~ack, s);
  endtask

  task automatic start();
    o_sda <= 1'b1;
    tick(HALF);
    rise();
    o_sda <= 1'b0;
    tick(HALF);
    o_scl <= 1'b0;
    tick(HALF);
  endtask

  task automatic stop();
    o_sda <= 1'b0;
    tick(HALF);
    rise();
    o_sda <= 1'b1;
    tick(HALF);
  endtask

  // Slave data must not move while clock is high
  always @(posedge i_sys_clk)
  begin
    if (reading && i_scl && p_scl && i_sda !== p_sda)
      hold_err++;
    p_scl <= i_scl;
    p_sda <= i_sda;
  end
endmodule

// *** verification/i2cs_slave_tb.sv ***
// Self-checking bench for the two-wire bus slave.
// Assumes the behavioural master model and pull-ups on both lines.
`timescale 1ns/1ps

module i2cs_slave_tb;
  import i2cs_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  i2cs_avs_req_s i_avs = '0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  i2cs_line_s o_line;
  logic o_slave_event;
  logic [8:0] o_baud_reload;
  logic scl, sda, m_scl, m_sda, ack;
  logic [31:0] rd, v;
  logic [7:0] b;
  logic [7:0] dv [4];
  logic [9:0] adr;
  logic [6:0] codes [5] = '{7'h00, 7'h03, 7'h79, 7'h7c, 7'h7f};
  logic [7:0] zoffs [5] = '{REG_RECEIVE_HOLDING, REG_BAUD_RELOAD, REG_BUS_STATUS,
    REG_OWN_ADDRESS, 8'h18};
  int errors = 0;
  int cmp_count = 0;
  int events = 0;
  int ev;
  int seed = 32'hd42c246d;

  assign scl = m_scl & (o_line.scl_oe_n | o_line.scl_o);
  assign sda = m_sda & (o_line.sda_oe_n | o_line.sda_o);

  i2cs_slave u_dut
  (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_avs(i_avs),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_scl(scl), .i_sda(sda), .o_line(o_line), .o_slave_event(o_slave_event),
    .o_baud_reload(o_baud_reload)
  );

  i2cs_master_model u_mst
  (
    .i_sys_clk(i_sys_clk), .i_scl(scl), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda)
  );

  initial forever #20 i_sys_clk = ~i_sys_clk;

  always @(posedge i_sys_clk)
    if (o_slave_event === 1'b1)
      events++;

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    logic wt;
    n = 0;
    @(posedge i_sys_clk);
    i_avs <= '{read: ~w, write: w, address: a, writedata: wd};
    do
    begin
      @(posedge i_sys_clk);
      wt = o_avs_waitrequest;
      rd = o_avs_readdata;
      n++;
    end
    while (wt !== 1'b0 && n < 20);
    i_avs <= '0;
    chk(32'(wt), 32'h0, "waitrequest");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  task automatic snd(input logic [7:0] x, input logic e);
    u_mst.send(x, ack);
    chk(32'(ack), 32'(e), "acknowledge");
  endtask

  // Read one byte while software loads it late
  task automatic fetch(input logic a, input logic [7:0] x, input logic [31:0] con);
    fork
      u_mst.recv(a, b);
      begin
        repeat (40) @(posedge i_sys_clk);
        chk(32'(scl), 32'h0, "clock held");
        wr(REG_TRANSMIT_HOLDING, 32'(x));
        wr(REG_BUS_CONTROL, con);
      end
    join
    chk(32'(b), 32'(x), "sent byte");
  endtask

  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge i_sys_clk);
    errors++;
    print_verdict();
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial
  begin
    foreach (dv[i]) dv[i] = 8'($random(seed));
    repeat (16) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    chk(32'({scl, sda, o_line.scl_o, o_line.sda_o}), 32'hc, "idle lines");
    rdc(REG_BUS_CONTROL, 32'(CON_RESET), "control reset");
    foreach (zoffs[i]) rdc(zoffs[i], 32'h0, "reset value");
    v = $random(seed);
    wr(REG_BAUD_RELOAD, v);
    rdc(REG_BAUD_RELOAD, 32'(v[8:0]), "baud");
    chk(32'(o_baud_reload), 32'(v[8:0]), "baud port");
    wr(REG_OWN_ADDRESS, v);
    rdc(REG_OWN_ADDRESS, 32'(v[9:0]), "own address");
    wr(REG_BUS_STATUS, 32'hffff);
    rdc(REG_BUS_STATUS, 32'hffc0, "status");
    wr(REG_BUS_STATUS, 32'h0);
    wr(REG_BUS_CONTROL, 32'h5a5a);
    rdc(REG_BUS_CONTROL, 32'h5a5a, "control");
    wr(8'h18, v);
    rdc(8'h18, 32'h0, "unmapped");
    adr = {3'($random(seed)), 7'h04 + 7'($unsigned($random(seed)) % 116)};
    wr(REG_OWN_ADDRESS, 32'(adr));
    wr(REG_BUS_CONTROL, 32'h1000);
    u_mst.start();
    snd({adr[6:0], 1'b0}, 1'b0);
    u_mst.stop();
    wr(REG_BUS_CONTROL, 32'h9000);
    foreach (codes[i])
    begin
      wr(REG_OWN_ADDRESS, 32'(codes[i]));
      u_mst.start();
      snd({codes[i], 1'b0}, 1'b0);
      u_mst.stop();
    end
    wr(REG_OWN_ADDRESS, 32'(adr));
    u_mst.start();
    snd({adr[6:0] ^ 7'h01, 1'b0}, 1'b0);
    u_mst.start();
    ev = events;
    snd({adr[6:0], 1'b0}, 1'b1);
    chk(events - ev, 1, "address event");
    rdc(REG_BUS_STATUS, 32'h0, "address status");
    snd(dv[0], 1'b1);
    rdc(REG_BUS_STATUS, 32'h21, "full");
    rdc(REG_RECEIVE_HOLDING, 32'(dv[0]), "holding");
    snd(dv[1], 1'b1);
    snd(dv[2], 1'b0);
    rdc(REG_RECEIVE_HOLDING, 32'(dv[1]), "kept");
    rdc(REG_BUS_STATUS, 32'h60, "overflow");
    snd(dv[3], 1'b0);
    rdc(REG_RECEIVE_HOLDING, 32'(dv[3]), "loaded");
    chk(events - ev, 5, "receive events");
    u_mst.stop();
    wr(REG_BUS_STATUS, 32'h0);
    u_mst.start();
    ev = events;
    snd({adr[6:0], 1'b1}, 1'b1);
    fetch(1'b1, dv[1], 32'h9000);
    fetch(1'b0, dv[2], 32'h9000);
    u_mst.stop();
    chk(events - ev, 3, "transmit events");
    chk(u_mst.hold_err + u_mst.stall_err, 0, "data held");
    adr = 10'($random(seed));
    wr(REG_OWN_ADDRESS, 32'(adr));
    wr(REG_BUS_CONTROL, 32'h9400);
    u_mst.start();
    snd({5'h1e, adr[9:8], 1'b0}, 1'b1);
    rdc(REG_BUS_STATUS, 32'h0, "partial match");
    snd(adr[7:0], 1'b1);
    bus(1'b0, REG_BUS_STATUS, 32'h0);
    chk(32'(rd[8]), 32'h1, "full match");
    u_mst.start();
    snd({5'h1e, adr[9:8], 1'b1}, 1'b1);
    fetch(1'b0, dv[0], 32'h9400);
    u_mst.start();
    snd({5'h1e, adr[9:8], 1'b0}, 1'b1);
    snd(~adr[7:0], 1'b0);
    u_mst.stop();
    print_verdict();
  end
endmodule
